// ==== pkg/spwm_pkg.sv ====
package spwm_pkg;
    // ----------------------------------------------------------------
    // register offsets (not byte addresses: some printed offsets are odd,
    // so each is an index and the byte address is four times it)
    // ----------------------------------------------------------------
    localparam logic [7:0] SPWM_IDX_IRQ_EN = 8'hA9;
    localparam logic [7:0] SPWM_IDX_IRQ_PRI = 8'hB9;
    localparam logic [7:0] SPWM_IDX_CFG_A = 8'hD1;
    localparam logic [7:0] SPWM_IDX_CTRL = 8'hD2;
    localparam logic [7:0] SPWM_IDX_PERIOD = 8'hD3;
    localparam logic [7:0] SPWM_IDX_CFG_B = 8'hD4;
    localparam logic [7:0] SPWM_IDX_W0 = 8'hD5;
    localparam logic [7:0] SPWM_IDX_W1 = 8'hD6;
    localparam logic [7:0] SPWM_IDX_W2 = 8'hD7;
    localparam logic [7:0] SPWM_IDX_W3 = 8'hDD;
    localparam logic [7:0] SPWM_IDX_W4 = 8'hDE;
    localparam logic [7:0] SPWM_IDX_W5 = 8'hDF;
    localparam logic [7:0] SPWM_IDX_IRQ_STAT = 8'hE0;
    localparam logic [7:0] SPWM_IDX_IRQ_MASK = 8'hE1;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int SPWM_CTRL_RUN_BIT = 7;
    localparam int SPWM_CTRL_FLAG_BIT = 6;
    localparam int SPWM_CTRL_PINLO_BIT = 3;
    localparam int SPWM_CTRL_DIV_BIT = 0;
    localparam int SPWM_CFG_INV_BIT = 3;
    localparam int SPWM_CFG_PINHI_BIT = 0;
    localparam int SPWM_IRQ_BIT = 1;

    // ----------------------------------------------------------------
    // reset values and masks
    // ----------------------------------------------------------------
    localparam logic [7:0] SPWM_RST_BYTE = 8'h00;
    localparam logic [7:0] SPWM_CFG_A_MASK = 8'h3F;
    localparam logic [7:0] SPWM_CFG_B_MASK = 8'h38;
    localparam logic [7:0] SPWM_IRQ_MASK_BITS = 8'h0E;
    localparam logic [7:0] SPWM_STAT_MASK = 8'h01;

    // bus answer states
    typedef enum logic [1:0] {
        SPWM_BUS_IDLE = 2'b01,
        SPWM_BUS_DONE = 2'b10
    } spwm_bus_t;
endpackage : spwm_pkg

// ==== core/spwm_prescale.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// counter clock prescaler: one-cycle tick every 1..256 system clocks
// ----------------------------------------------------------------
module spwm_prescale (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    output logic tick_o
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic [7:0] last_w;

    // divider select to terminal count
    function automatic logic [7:0] spwm_last(input logic [2:0] sel);
        case (sel)
            3'h0: spwm_last = 8'h00;
            3'h1: spwm_last = 8'h01;
            3'h2: spwm_last = 8'h03;
            3'h3: spwm_last = 8'h07;
            3'h4: spwm_last = 8'h1F;
            3'h5: spwm_last = 8'h3F;
            3'h6: spwm_last = 8'h7F;
            default: spwm_last = 8'hFF;
        endcase
    endfunction : spwm_last

    assign last_w = spwm_last(sel_i);
    assign tick_o = run_i && (cnt_q >= last_w);
    assign cnt_d = (!run_i || tick_o) ? 8'h00 : cnt_q + 8'h01;

    // prescale counter, held clear while stopped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
        end
    end
endmodule : spwm_prescale
`default_nettype wire

// ==== core/spwm_chan.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// one channel: compare, invert, pin routing
// ----------------------------------------------------------------
module spwm_chan #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] count_i,
    input wire logic [WIDTH-1:0] width_i,
    input wire logic invert_i,
    input wire logic pin_en_i,
    input wire logic gpio_i,
    output logic pin_o
);
    logic wave_w;

    assign wave_w = (count_i < width_i);
    assign pin_o = pin_en_i ? (wave_w ^ invert_i) : gpio_i;
endmodule : spwm_chan
`default_nettype wire

// ==== core/spwm_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// How it works
// - channels 0..2 invert when bits 5..3 of the first config register are set.
// - channels 3..5 invert when bits 5..3 of the second config register are set.
// - channels 5..3 reach their pins only when bits 2..0 of the first config register are set.
// - each channel has an 8-bit width register giving its high time in counter clocks.
// - overflow requests an interrupt only while bit 1 of the enable register is set.
// - bit 1 of the priority register set means high priority, clear means low.
// - counter and waveforms run only while the module run bit is set.
// - a channel with its pin enable clear hands the pin to general-purpose I/O.
// - with all pins released the counter still runs as an 8-bit timer with interrupts.
// - all six channels share one counter, one period and one interrupt request.
// - after reaching the period value the next counter clock returns the count to zero.
// - overflow past the period sets the overflow flag in hardware.
// - the counter clock is the system clock divided by 1,2,4,8,32,64,128 or 256.
// - clearing the run bit stops the unit and zeroes the counter.
module spwm_top #(
    parameter int CHANNELS = 6,
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [5:0] gpio_i,
    output logic [5:0] pin_o,
    output logic irq_req_o,
    output logic irq_high_pri_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] period_q;
    logic [7:0] period_act_q;
    logic [7:0] cfg_a_q;
    logic [7:0] cfg_b_q;
    logic [7:0] irq_en_q;
    logic [7:0] irq_pri_q;
    logic [7:0] stat_q;
    logic [7:0] mask_q;
    logic [WIDTH-1:0] width_q [CHANNELS];
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic [7:0] ctrl_d;
    logic [7:0] ctrl_wr_w;
    logic [7:0] period_d;
    logic [7:0] period_act_d;
    logic [7:0] cfg_a_d;
    logic [7:0] cfg_b_d;
    logic [7:0] irq_en_d;
    logic [7:0] irq_pri_d;
    logic [7:0] stat_d;
    logic [7:0] stat_clr_w;
    logic [7:0] mask_d;

    // ----------------------------------------------------------------
    // bus side signals
    // ----------------------------------------------------------------
    spwm_pkg::spwm_bus_t bus_q;
    spwm_pkg::spwm_bus_t bus_d;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic [7:0] idx_w;
    logic [7:0] wbyte_w;
    logic [7:0] rdata_w;
    logic setup_w;
    logic access_w;
    logic wr_w;
    logic known_w;
    logic we_ctrl_w;
    logic we_period_w;
    logic we_cfg_a_w;
    logic we_cfg_b_w;
    logic we_irq_en_w;
    logic we_irq_pri_w;
    logic we_stat_w;
    logic we_mask_w;
    logic [CHANNELS-1:0] width_we_w;

    // ----------------------------------------------------------------
    // counter and channel signals
    // ----------------------------------------------------------------
    logic run_w;
    logic tick_w;
    logic wrap_w;
    logic ovf_w;
    logic [5:0] pin_en_w;
    logic [5:0] invert_w;
    logic [5:0] pin_w;
    logic [WIDTH-1:0] chan_width_w [CHANNELS];

    // ----------------------------------------------------------------
    // output flip-flops
    // ----------------------------------------------------------------
    logic [5:0] pin_q;
    logic irq_req_q;
    logic irq_q;

    // ----------------------------------------------------------------
    // helper functions
    // ----------------------------------------------------------------
    // one register index against another; shared by strobes, read mux and error
    function automatic logic spwm_hit(input logic [7:0] idx, input logic [7:0] ref_idx);
        spwm_hit = (idx == ref_idx);
    endfunction : spwm_hit

    // byte with a single bit set at a field position
    function automatic logic [7:0] spwm_onehot(input int pos);
        spwm_onehot = 8'h01 << pos;
    endfunction : spwm_onehot

    // index of the width register of a channel
    function automatic logic [7:0] spwm_width_idx(input int ch);
        case (ch)
            0: spwm_width_idx = spwm_pkg::SPWM_IDX_W0;
            1: spwm_width_idx = spwm_pkg::SPWM_IDX_W1;
            2: spwm_width_idx = spwm_pkg::SPWM_IDX_W2;
            3: spwm_width_idx = spwm_pkg::SPWM_IDX_W3;
            4: spwm_width_idx = spwm_pkg::SPWM_IDX_W4;
            default: spwm_width_idx = spwm_pkg::SPWM_IDX_W5;
        endcase
    endfunction : spwm_width_idx

    // sticky bits: clear where asked, a set in the same cycle wins
    function automatic logic [7:0] spwm_sticky(input logic [7:0] cur, input logic [7:0] clr,
        input logic [7:0] set);
        spwm_sticky = (cur & ~clr) | set;
    endfunction : spwm_sticky

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    // index is the word address; the two low address bits are ignored
    assign idx_w = paddr_i[9:2];
    assign wbyte_w = pwdata_i[7:0];
    // setup seen while idle; the access completes on the answered cycle
    assign setup_w = psel_i && !penable_i && (bus_q == spwm_pkg::SPWM_BUS_IDLE);
    assign access_w = psel_i && penable_i && pready_q;
    // only byte lane 0 carries register data
    assign wr_w = access_w && pwrite_i && pstrb_i[0];

    // answer state: one answer cycle after every setup, no further waits
    assign bus_d = setup_w ? spwm_pkg::SPWM_BUS_DONE :
        ((access_w || !psel_i) ? spwm_pkg::SPWM_BUS_IDLE : bus_q);

    // write strobes, one per register
    assign we_ctrl_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CTRL);
    assign we_period_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_PERIOD);
    assign we_cfg_a_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_A);
    assign we_cfg_b_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_B);
    assign we_irq_en_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_EN);
    assign we_irq_pri_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_PRI);
    assign we_stat_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_STAT);
    assign we_mask_w = wr_w && spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_MASK);

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_width_we
        assign width_we_w[ch] = wr_w && spwm_hit(idx_w, spwm_width_idx(ch));
    end

    // any mapped register; other indices answer with an error
    assign known_w = spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_EN) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_PRI) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_A) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CTRL) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_PERIOD) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_B) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W0) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W1) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W2) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W3) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W4) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W5) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_STAT) ||
        spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_MASK);

    // read mux; reserved bits are never stored, so they read zero
    assign rdata_w = ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_EN)}} & irq_en_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_PRI)}} & irq_pri_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_A)}} & cfg_a_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CTRL)}} & ctrl_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_PERIOD)}} & period_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_CFG_B)}} & cfg_b_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W0)}} & 8'(width_q[0])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W1)}} & 8'(width_q[1])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W2)}} & 8'(width_q[2])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W3)}} & 8'(width_q[3])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W4)}} & 8'(width_q[4])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_W5)}} & 8'(width_q[5])) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_STAT)}} & stat_q) |
        ({8{spwm_hit(idx_w, spwm_pkg::SPWM_IDX_IRQ_MASK)}} & mask_q);

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    // run bit and routing bits land as written
    assign ctrl_wr_w = we_ctrl_w ? wbyte_w : ctrl_q;
    // overflow sets the flag, and wins over a clearing write
    assign ctrl_d = spwm_sticky(ctrl_wr_w, 8'h00,
        ovf_w ? spwm_onehot(spwm_pkg::SPWM_CTRL_FLAG_BIT) : 8'h00);
    // shared period as written; used from the next wrap on
    assign period_d = we_period_w ? wbyte_w : period_q;
    // reserved bits of the first group masked
    assign cfg_a_d = we_cfg_a_w ? (wbyte_w & spwm_pkg::SPWM_CFG_A_MASK) : cfg_a_q;
    assign cfg_b_d = we_cfg_b_w ? (wbyte_w & spwm_pkg::SPWM_CFG_B_MASK) : cfg_b_q;
    assign irq_en_d = we_irq_en_w ? (wbyte_w & spwm_pkg::SPWM_IRQ_MASK_BITS) : irq_en_q;
    assign irq_pri_d = we_irq_pri_w ? (wbyte_w & spwm_pkg::SPWM_IRQ_MASK_BITS) : irq_pri_q;
    // status bit: write one to clear, overflow sets it again
    assign stat_clr_w = we_stat_w ? (wbyte_w & spwm_pkg::SPWM_STAT_MASK) : 8'h00;
    assign stat_d = spwm_sticky(stat_q, stat_clr_w, ovf_w ? spwm_pkg::SPWM_STAT_MASK : 8'h00);
    assign mask_d = we_mask_w ? (wbyte_w & spwm_pkg::SPWM_STAT_MASK) : mask_q;
    // new period takes hold at the wrap, or at once while stopped
    assign period_act_d = (!run_w || ovf_w) ? period_q : period_act_q;

    // ----------------------------------------------------------------
    // shared counter
    // ----------------------------------------------------------------
    // counting only with run bit
    assign run_w = ctrl_q[spwm_pkg::SPWM_CTRL_RUN_BIT];

    spwm_prescale i_prescale (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(run_w),
        .sel_i(ctrl_q[spwm_pkg::SPWM_CTRL_DIV_BIT +: 3]),
        .tick_o(tick_w)
    );

    assign wrap_w = (count_q == WIDTH'(period_act_q));
    assign ovf_w = tick_w && wrap_w;
    assign count_d = !run_w ? '0 :
        (tick_w ? (wrap_w ? '0 : WIDTH'(count_q + WIDTH'(1))) : count_q);

    // ----------------------------------------------------------------
    // channels
    // ----------------------------------------------------------------
    // pin enables: 5..3 from the first config register, 2..0 from the control register
    assign pin_en_w = {cfg_a_q[spwm_pkg::SPWM_CFG_PINHI_BIT +: 3],
        ctrl_q[spwm_pkg::SPWM_CTRL_PINLO_BIT +: 3]};
    assign invert_w = {cfg_b_q[spwm_pkg::SPWM_CFG_INV_BIT +: 3],
        cfg_a_q[spwm_pkg::SPWM_CFG_INV_BIT +: 3]};

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        assign chan_width_w[ch] = run_w ? width_q[ch] : '0;
        spwm_chan #(
            .WIDTH(WIDTH)
        ) i_chan (
            .count_i(count_q),
            .width_i(chan_width_w[ch]),
            .invert_i(invert_w[ch]),
            .pin_en_i(pin_en_w[ch]),
            .gpio_i(gpio_i[ch]),
            .pin_o(pin_w[ch])
        );
    end

    // ----------------------------------------------------------------
    // flip-flops
    // ----------------------------------------------------------------
    // bus answer; read data and error are taken at setup
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            bus_q <= spwm_pkg::SPWM_BUS_IDLE;
            pready_q <= 1'h0;
            pslverr_q <= 1'h0;
            prdata_q <= 32'h0000_0000;
        end else begin
            bus_q <= bus_d;
            pready_q <= (bus_d == spwm_pkg::SPWM_BUS_DONE);
            if (setup_w) begin
                prdata_q <= {24'h00_0000, rdata_w};
                pslverr_q <= !known_w;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= spwm_pkg::SPWM_RST_BYTE;
            period_q <= spwm_pkg::SPWM_RST_BYTE;
            period_act_q <= spwm_pkg::SPWM_RST_BYTE;
            cfg_a_q <= spwm_pkg::SPWM_RST_BYTE;
            cfg_b_q <= spwm_pkg::SPWM_RST_BYTE;
            irq_en_q <= spwm_pkg::SPWM_RST_BYTE;
            irq_pri_q <= spwm_pkg::SPWM_RST_BYTE;
            stat_q <= spwm_pkg::SPWM_RST_BYTE;
            mask_q <= spwm_pkg::SPWM_RST_BYTE;
            count_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            period_q <= period_d;
            period_act_q <= period_act_d;
            cfg_a_q <= cfg_a_d;
            cfg_b_q <= cfg_b_d;
            irq_en_q <= irq_en_d;
            irq_pri_q <= irq_pri_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int c = 0; c < CHANNELS; c++) begin
                width_q[c] <= '0;
            end
        end else begin
            for (int c = 0; c < CHANNELS; c++) begin
                if (width_we_w[c]) begin
                    width_q[c] <= wbyte_w[WIDTH-1:0];
                end
            end
        end
    end

    // interrupt outputs from next values, so they follow a write at once; pins from current values
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_q <= 6'h00;
            irq_req_q <= 1'h0;
            irq_q <= 1'h0;
        end else begin
            pin_q <= pin_w;
            irq_req_q <= ctrl_d[spwm_pkg::SPWM_CTRL_FLAG_BIT] && irq_en_d[spwm_pkg::SPWM_IRQ_BIT];
            irq_q <= |(stat_d & mask_d);
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign pin_o = pin_q;
    assign irq_req_o = irq_req_q;
    assign irq_o = irq_q;
    assign irq_high_pri_o = irq_pri_q[spwm_pkg::SPWM_IRQ_BIT];
endmodule : spwm_top
`default_nettype wire

// ==== dv/spwm_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module spwm_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic pready_o,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic [5:0] gpio_i,
    input wire logic [5:0] pin_o,
    input wire logic irq_req_o,
    input wire logic irq_high_pri_o,
    input wire logic irq_o
);
    logic [7:0] sh_q [256];
    wire acc = psel_i & penable_i & pready_o;
    wire wr = acc & pwrite_i;
    wire rd = acc & ~pwrite_i;
    wire [7:0] ix = paddr_i[9:2];
    wire [7:0] ctl = sh_q[8'hD2];
    wire [5:0] en = {sh_q[8'hD1][2:0], ctl[5:3]};
    // mirror of software writes
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) sh_q <= '{default: 8'h00};
        else if (wr) sh_q[ix] <= pwdata_i[7:0];
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    gpio_pass_a: assert property (!$past(rst_i) |->
        ((pin_o ^ $past(gpio_i)) & ~$past(en)) == 0) else $error("pin");
    irq_gate_a: assert property (!sh_q[8'hA9][1] |-> !irq_req_o) else $error("req");
    irq_pri_a: assert property (irq_high_pri_o == sh_q[8'hB9][1]) else $error("pri");
    irq_mask_a: assert property (!sh_q[8'hE1][0] |-> !irq_o) else $error("mask");
    stop_hold_a: assert property (!$past(rst_i, 2) && !$past(ctl[7], 2) &&
        !$past(ctl[7], 3) && !$past(wr, 2) && $past(gpio_i) == $past(gpio_i, 2)
        |-> $stable(pin_o)) else $error("stop");
    rise_cause_a: assert property ($rose(irq_req_o) |-> $past(ctl[7]) || $past(wr))
        else $error("rise");
    rsvd_top_a: assert property (rd |-> prdata_o[31:8] == 0) else $error("upper");
    rsvd_cfgb_a: assert property (rd && ix == 8'hD4 |-> (prdata_o[7:0] & 8'hC7) == 0)
        else $error("cfg b");
endmodule : spwm_props
`default_nettype wire

// ==== dv/spwm_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module spwm_top_tb;
    logic clk_i, rst_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o, p;
    logic irq_req_o, irq_high_pri_o, irq_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic [3:0] pstrb_i;
    logic [5:0] gpio_i, pin_o;
    logic [7:0] q;
    logic err;
    int fail_count, checks, hi0, hi3, up0;
    // divider select, width, invert, rising edges, high cycles per 1024
    int rows [8][5] = '{'{0, 1, 0, 256, 256}, '{1, 2, 1, 128, 512}, '{2, 3, 0, 64, 768},
        '{3, 1, 1, 32, 768}, '{4, 2, 0, 8, 512}, '{5, 3, 1, 4, 256}, '{6, 1, 0, 2, 256},
        '{7, 0, 1, 0, 1024}};
    logic [7:0] ids [12] = '{8'hA9, 8'hB9, 8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6,
        8'hD7, 8'hDD, 8'hDE, 8'hDF};
    spwm_top i_dut (.*);
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        psel_i <= 1'h1;
        pwrite_i <= w;
        paddr_i <= {2'h0, a, 2'h0};
        pwdata_i <= {24'h0, d};
        @(posedge clk_i);
        penable_i <= 1'h1;
        do @(posedge clk_i); while (pready_o !== 1'h1);
        q = prdata_o[7:0];
        err = pslverr_o;
        psel_i <= 1'h0;
        penable_i <= 1'h0;
        @(posedge clk_i);
    endtask : bus
    task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", s, e, g);
        end
    endtask : cmp
    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test
    // clock and watchdog
    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        fail_count++;
        finish_test();
    end
    // main sequence
    initial begin
        {psel_i, penable_i, pwrite_i, rst_i} = 4'h1;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        pstrb_i = 4'hF;
        gpio_i = 6'h2A;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'h0;
        bus(8'hC0, 1'h1, 8'hFF);
        cmp("slave error", 32'h1, 32'(err));
        foreach (ids[i]) begin
            bus(ids[i], 1'h0, 8'h00);
            cmp("reset value", 32'h0, 32'(q));
        end
        cmp("no error", 32'h0, 32'(err));
        bus(8'hD4, 1'h1, 8'hFF);
        bus(8'hD4, 1'h0, 8'h00);
        cmp("cfg b", 32'h38, 32'(q));
        bus(8'hD3, 1'h1, 8'h03);
        foreach (rows[i]) begin
            bus(8'hD5, 1'h1, 8'(rows[i][1]));
            bus(8'hDD, 1'h1, 8'(rows[i][1]));
            bus(8'hD1, 1'h1, 8'h01 | 8'(rows[i][2] << 3));
            bus(8'hD4, 1'h1, 8'h08 ^ 8'(rows[i][2] << 3));
            bus(8'hD2, 1'h1, 8'h88 + 8'(rows[i][0]));
            repeat (1300) @(posedge clk_i);
            {hi0, hi3, up0} = '0;
            p = pin_o[0];
            repeat (1024) begin
                @(posedge clk_i);
                hi0 += int'(pin_o[0]);
                hi3 += int'(pin_o[3]);
                up0 += int'(pin_o[0] & ~p);
                p = pin_o[0];
            end
            cmp("ch0 high", 32'(rows[i][4]), 32'(hi0));
            cmp("ch3 high", 32'(1024 - rows[i][4]), 32'(hi3));
            cmp("periods", 32'(rows[i][3]), 32'(up0));
        end
        gpio_i <= 6'h15;
        bus(8'hD1, 1'h1, 8'h00);
        bus(8'hD2, 1'h1, 8'h00);
        bus(8'hD2, 1'h1, 8'h00);
        bus(8'hE0, 1'h1, 8'h01);
        bus(8'hA9, 1'h1, 8'h02);
        bus(8'hE1, 1'h1, 8'h01);
        bus(8'hB9, 1'h1, 8'h02);
        cmp("irq stopped", 32'h1, 32'({irq_req_o, irq_o, irq_high_pri_o}));
        cmp("gpio", 32'h15, 32'(pin_o));
        bus(8'hD2, 1'h1, 8'h80);
        repeat (8) @(posedge clk_i);
        cmp("irq run", 32'h7, 32'({irq_req_o, irq_o, irq_high_pri_o}));
        bus(8'hE1, 1'h1, 8'h00);
        cmp("irq masked", 32'h5, 32'({irq_req_o, irq_o, irq_high_pri_o}));
        bus(8'hA9, 1'h1, 8'h00);
        bus(8'hB9, 1'h1, 8'h00);
        cmp("irq off", 32'h0, 32'({irq_req_o, irq_o, irq_high_pri_o}));
        finish_test();
    end
endmodule : spwm_top_tb
bind spwm_top spwm_props i_props (.*);
`default_nettype wire
